//--- rtl/vic_pkg.sv
// Package of constants and types for the vectored interrupt control block
// Functional notes
// [R01] The base variant serves 21 sources (8 external, 12 internal, 1 software) through 16 vectors.
// [R02] The two-wire variant serves 23 sources (9 external, 13 internal, 1 software) through 16 vectors.
// [R03] Every source but reset and the software break is governed by its request bit, its enable bit and the global disable flag.
// [R04] An interrupt is raised only when request is 1, enable is 1 and the disable flag is 0.
// [R05] Software may write each enable bit to 1 or 0.
// [R06] Software may clear a request bit, and writing 1 to it has no effect.
// [R07] Reset and the software break are always taken, whatever the enables and flag.
// [R08] While the disable flag is set, all interrupts but reset and software break are masked.
// [R09] Simultaneous enabled requests are presented one by one, highest fixed priority first.
// [R10] On acceptance the core stacks state, the disable flag is set, the request bit clears and the vector loads.
// [R11] Where two sources share a vector, a source selection bit picks which one drives the request.
// [R12] A switch bit picks which of two pins feeds each relocatable external interrupt.
// [R13] Changing an edge or source selection may set the request bit; software disables, changes, clears, re-enables.
// [R14] A request bit stays set until software clears it or the core accepts it, whatever the enable bit.
// [R15] After reset all request, enable and selection bits are 0 and the disable flag is set; source_select_in is an input and is not reset.
package vic_pkg;
    // =========================================================
    // Sizes
    localparam int VIC_VECTORS = 16;
    localparam int VIC_REQS = 15;
    localparam int VIC_PAIRS = 8;
    localparam int VIC_SRC_BASE = 21;
    localparam int VIC_SRC_TWI = 23;
    localparam logic [1:0] VIC_SYNC_FILL = 2'h3;
    // =========================================================
    // Vector numbers, priority order
    localparam logic [3:0] VIC_VEC_RESET = 4'h0;
    localparam logic [3:0] VIC_VEC_BREAK = 4'hf;
    // =========================================================
    // Reset values
    localparam logic [14:0] VIC_REQ_RST = 15'h0000;
    localparam logic [14:0] VIC_EN_RST = 15'h0000;
    localparam logic [7:0] VIC_SEL_RST = 8'h00;
    localparam logic VIC_IDIS_RST = 1'b1;
    localparam logic [3:0] VIC_EDGE_RST = 4'h0;
    // =========================================================
    // Core handshake states
    typedef enum logic [2:0]
    {
        VIC_IDLE = 3'b001,
        VIC_OFFER = 3'b010,
        VIC_SETTLE = 3'b100
    } vic_state_t;
endpackage : vic_pkg

//--- rtl/vic_edge_if.sv
// Interface carrying raw external pin levels and detected rise and fall pulses
`timescale 1ns/1ps
`default_nettype none
interface vic_edge_if;
    logic [8:0] level;
    logic [8:0] rise;
    logic [8:0] fall;
    modport detector (input level, output rise, output fall);
    modport user (output level, input rise, input fall);
endinterface : vic_edge_if
`default_nettype wire

//--- rtl/vic_edge_detect.sv
// Edge detector for external interrupt lines, six flops per pin
`timescale 1ns/1ps
`default_nettype none
module vic_edge_detect
    import vic_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_in,
    vic_edge_if.detector edge_bus
);
    logic [8:0] sync1_reg;
    logic [8:0] sync2_reg;
    logic [8:0] sync3_reg;
    logic [8:0] stable_reg;
    logic [1:0] fill_reg;
    logic [8:0] agree;
    logic [8:0] rise_reg;
    logic [8:0] fall_reg;

    // =========================================================
    // Synchroniser chain
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            sync1_reg <= 9'h000;
            sync2_reg <= 9'h000;
            sync3_reg <= 9'h000;
        end
        else
        begin
            sync1_reg <= edge_bus.level;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // =========================================================
    // Settled level, primed from the pins so no false edge follows reset
    assign agree = ~(sync2_reg ^ sync3_reg);

    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            fill_reg <= 2'h0;
            stable_reg <= 9'h000;
        end
        else if (fill_reg != VIC_SYNC_FILL)
        begin
            fill_reg <= fill_reg + 2'h1;
            stable_reg <= sync2_reg;
        end
        else
        begin
            stable_reg <= (agree & sync3_reg) | (~agree & stable_reg);
        end
    end

    // =========================================================
    // Edge pulses once second and third stage agree on a new level
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            rise_reg <= 9'h000;
            fall_reg <= 9'h000;
        end
        else if (fill_reg != VIC_SYNC_FILL)
        begin
            rise_reg <= 9'h000;
            fall_reg <= 9'h000;
        end
        else
        begin
            rise_reg <= agree & sync3_reg & ~stable_reg;
            fall_reg <= agree & ~sync3_reg & stable_reg;
        end
    end

    assign edge_bus.rise = rise_reg;
    assign edge_bus.fall = fall_reg;
endmodule : vic_edge_detect
`default_nettype wire

//--- rtl/vic_top.sv
// Vectored interrupt controller with request latches and fixed priority
`timescale 1ns/1ps
`default_nettype none
module vic_top
    import vic_pkg::*;
#(
    parameter bit TWI_VARIANT = 1'b0
)
(
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // External pins: 0 int0a,1 int0b,2 int1,3 int2,4 int3,5 int4a,6 int4b,
    // 7 cntr0,8 cntr1; cntr2 and two-wire event arrive internally
    input wire logic ext_irq_zero_pin_a_in,
    input wire logic ext_irq_zero_pin_b_in,
    input wire logic ext_irq_one_in,
    input wire logic ext_irq_two_in,
    input wire logic ext_irq_three_in,
    input wire logic ext_irq_four_pin_a_in,
    input wire logic ext_irq_four_pin_b_in,
    input wire logic counter0_pin_in,
    input wire logic counter1_pin_in,
    input wire logic [8:0] edge_polarity_in,
    input wire logic ext_pin_switch_in,
    // Internal peripheral event pulses (same clock)
    input wire logic timer_z_evt_in,
    input wire logic serial1_rx_evt_in,
    input wire logic serial1_tx_evt_in,
    input wire logic timer_x_evt_in,
    input wire logic timer_y_evt_in,
    input wire logic timer_1_evt_in,
    input wire logic timer_2_evt_in,
    input wire logic serial3_rx_evt_in,
    input wire logic serial2_evt_in,
    input wire logic counter2_evt_in,
    input wire logic adc_evt_in,
    input wire logic serial3_tx_evt_in,
    input wire logic twi_evt_in,
    input wire logic twi_line_evt_in,
    // Control from the core
    input wire logic [7:0] source_select_in,
    input wire logic [14:0] enable_wr_data_in,
    input wire logic enable_wr_in,
    input wire logic [14:0] request_wr_data_in,
    input wire logic request_wr_in,
    input wire logic set_idis_in,
    input wire logic clear_idis_in,
    input wire logic software_break_instruction_in,
    input wire logic accept_in,
    // To the core
    output logic irq_out,
    output logic [3:0] vector_out,
    output logic [14:0] request_out,
    output logic [14:0] enable_out,
    output logic idis_out
);
    vic_edge_if edge_bus ();
    logic [14:0] req_reg;
    logic [14:0] en_reg;
    logic idis_reg;
    logic irq_reg;
    logic [3:0] vec_reg;
    vic_state_t state_reg;
    logic [14:0] events;
    logic [8:0] pin_evt;
    logic [14:0] live;
    logic [14:0] take_mask;
    logic break_pending_reg;
    logic offer_brk_reg;

    // =========================================================
    // Edge detection of external pins
    assign edge_bus.level = {counter1_pin_in, counter0_pin_in,
        ext_irq_four_pin_b_in, ext_irq_four_pin_a_in, ext_irq_three_in,
        ext_irq_two_in, ext_irq_one_in, ext_irq_zero_pin_b_in,
        ext_irq_zero_pin_a_in};

    vic_edge_detect u_edge (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .edge_bus(edge_bus)
    );

    assign pin_evt = (edge_bus.rise & edge_polarity_in)
        | (edge_bus.fall & ~edge_polarity_in);

    // =========================================================
    // Source routing onto the fifteen maskable request lines
    always_comb
    begin
        events = 15'h0000;
        // Pin switch for relocatable externals see [R12]
        // Shared vectors picked by selection bits see [R11]
        events[0] = source_select_in[0] ? timer_z_evt_in
            : (ext_pin_switch_in ? pin_evt[1] : pin_evt[0]);
        events[1] = pin_evt[2];
        events[2] = serial1_rx_evt_in;
        events[3] = (source_select_in[1] && TWI_VARIANT) ? twi_line_evt_in
            : serial1_tx_evt_in;
        events[4] = timer_x_evt_in;
        events[5] = timer_y_evt_in;
        events[6] = timer_1_evt_in;
        events[7] = timer_2_evt_in;
        events[8] = (source_select_in[2] && TWI_VARIANT) ? twi_line_evt_in
            : pin_evt[7];
        events[9] = source_select_in[3] ? serial3_rx_evt_in : pin_evt[8];
        events[10] = source_select_in[4] ? timer_z_evt_in : serial2_evt_in;
        events[11] = (source_select_in[5] && TWI_VARIANT) ? twi_evt_in
            : pin_evt[3];
        events[12] = pin_evt[4];
        events[13] = source_select_in[6] ? counter2_evt_in
            : (ext_pin_switch_in ? pin_evt[6] : pin_evt[5]);
        events[14] = source_select_in[7] ? serial3_tx_evt_in : adc_evt_in;
    end

    // =========================================================
    // Fixed priority pick, lowest index wins
    function automatic logic [3:0] vic_pick(input logic [14:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = VIC_REQS - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction : vic_pick

    assign live = req_reg & en_reg & {VIC_REQS{~idis_reg}}; // see [R03] [R04] [R08]
    assign take_mask = (state_reg == VIC_OFFER && accept_in && vec_reg != 4'h0
        && !offer_brk_reg)
        ? (15'h0001 << (vec_reg - 4'h1)) : 15'h0000;

    // =========================================================
    // Request latches: set wins over clear
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            req_reg <= VIC_REQ_RST; // see [R15]
        end
        else
        begin
            // Write 1 keeps, write 0 clears; events hold until cleared see [R06] [R14] [R13]
            req_reg <= ((req_reg & ~take_mask)
                & (request_wr_in ? request_wr_data_in : 15'h7fff)) | events; // see [R10]
        end
    end

    // =========================================================
    // Enable bits
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            en_reg <= VIC_EN_RST; // see [R15]
        end
        else if (enable_wr_in)
        begin
            en_reg <= enable_wr_data_in; // see [R05]
        end
    end

    // =========================================================
    // Global disable flag
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            idis_reg <= VIC_IDIS_RST; // see [R15]
        end
        else if (state_reg == VIC_OFFER && accept_in)
        begin
            idis_reg <= 1'b1; // see [R10]
        end
        else if (set_idis_in)
        begin
            idis_reg <= 1'b1;
        end
        else if (clear_idis_in)
        begin
            idis_reg <= 1'b0;
        end
    end

    // =========================================================
    // Software break latch, unmaskable
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            break_pending_reg <= 1'b0;
        end
        else if (software_break_instruction_in)
        begin
            break_pending_reg <= 1'b1; // see [R07]
        end
        else if (state_reg == VIC_OFFER && accept_in && offer_brk_reg)
        begin
            break_pending_reg <= 1'b0;
        end
    end

    // =========================================================
    // Offer to the core, one at a time
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            // Reset vector is offered first, unconditionally see [R07]
            state_reg <= VIC_OFFER;
            irq_reg <= 1'b1;
            vec_reg <= VIC_VEC_RESET;
            offer_brk_reg <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                VIC_IDLE:
                begin
                    if (break_pending_reg)
                    begin
                        state_reg <= VIC_OFFER;
                        irq_reg <= 1'b1;
                        vec_reg <= VIC_VEC_BREAK; // see [R07] [R08]
                        offer_brk_reg <= 1'b1;
                    end
                    else if (|live)
                    begin
                        state_reg <= VIC_OFFER;
                        irq_reg <= 1'b1;
                        vec_reg <= vic_pick(live) + 4'h1; // see [R09] [R01] [R02]
                        offer_brk_reg <= 1'b0;
                    end
                end
                VIC_OFFER:
                begin
                    if (accept_in)
                    begin
                        state_reg <= VIC_SETTLE;
                        irq_reg <= 1'b0;
                    end
                    else if (vec_reg != VIC_VEC_RESET
                        && !offer_brk_reg
                        && !live[vec_reg - 4'h1])
                    begin
                        // Request withdrawn or masked before acceptance
                        state_reg <= VIC_IDLE;
                        irq_reg <= 1'b0;
                    end
                end
                VIC_SETTLE:
                begin
                    state_reg <= VIC_IDLE;
                end
                default:
                begin
                    state_reg <= VIC_IDLE;
                    irq_reg <= 1'b0;
                end
            endcase
        end
    end

    assign irq_out = irq_reg;
    assign vector_out = vec_reg;
    assign request_out = req_reg;
    assign enable_out = en_reg;
    assign idis_out = idis_reg;
endmodule : vic_top
`default_nettype wire

//--- sim/vic_core_model.sv
// Behavioural core that takes the offered interrupt vectors
`timescale 1ns/1ps
`default_nettype none
module vic_core_model
(
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic irq_in,
    input wire logic [3:0] vector_in,
    input wire logic hold_in,
    input wire logic [3:0] delay_in,
    output logic accept_out,
    output logic [3:0] last_vec_out
);
    logic [3:0] wait_reg;
    // ====================
    // Stall count while an offer stands; vector fetch on acceptance
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in || !irq_in || accept_out)
            wait_reg <= 4'h0;
        else if (wait_reg != 4'hf)
            wait_reg <= wait_reg + 4'h1;
        if (irq_in && accept_out)
            last_vec_out <= vector_in;
    end
    // ====================
    // Accept raised after a falling edge, held over one rising edge
    always_ff @(negedge sys_clk_in)
    begin
        accept_out <= !reset_in && irq_in && !hold_in && !accept_out
            && wait_reg >= delay_in;
    end
endmodule : vic_core_model
`default_nettype wire

//--- sim/vic_chk.sv
// Port level checker for the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
module vic_chk
    import vic_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic enable_wr_in,
    input wire logic [14:0] enable_wr_data_in,
    input wire logic request_wr_in,
    input wire logic software_break_instruction_in,
    input wire logic accept_in,
    input wire logic irq_out,
    input wire logic [3:0] vector_out,
    input wire logic [14:0] request_out,
    input wire logic [14:0] enable_out,
    input wire logic idis_out
);
    logic [14:0] live_reg;
    // ====================
    // Lines that were live one cycle back
    always_ff @(posedge sys_clk_in)
    begin
        live_reg <= request_out & enable_out & {15{~idis_out}};
    end
    default clocking dc @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    chk_reset_state: assert property (disable iff (1'b0) reset_in |=>
        idis_out && request_out == 15'h0000 && enable_out == 15'h0000) else $error("reset state wrong");
    chk_reset_offer: assert property ($fell(reset_in) |->
        irq_out && vector_out == VIC_VEC_RESET) else $error("reset vector not offered");
    chk_offer_live: assert property (irq_out && vector_out inside {[4'h1:4'he]} |->
        live_reg[vector_out - 4'h1]) else $error("offer of a line not live");
    chk_accept_clears: assert property (irq_out && accept_in && vector_out inside {[4'h1:4'he]} |=>
        !irq_out && idis_out && !request_out[$past(vector_out) - 4'h1]) else $error("accept effects missing");
    chk_settle_gap: assert property (irq_out && accept_in |=>
        !irq_out [*2]) else $error("offers not one by one");
    chk_masked_idle: assert property (!irq_out && idis_out && !software_break_instruction_in |=>
        !irq_out || vector_out == VIC_VEC_BREAK) else $error("offer while disabled");
    chk_request_holds: assert property (!request_wr_in && !(irq_out && accept_in) |=>
        (request_out & $past(request_out)) == $past(request_out)) else $error("request lost");
    chk_enable_load: assert property (enable_wr_in |=>
        enable_out == $past(enable_wr_data_in)) else $error("enable not loaded");
    chk_break_taken: assert property (software_break_instruction_in && !irq_out && (request_out & enable_out) == 15'h0000 |->
        ##[1:3] irq_out && vector_out == VIC_VEC_BREAK) else $error("break not offered");
endmodule : vic_chk
bind vic_top vic_chk chk_u (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .enable_wr_in(enable_wr_in), .enable_wr_data_in(enable_wr_data_in),
    .request_wr_in(request_wr_in), .accept_in(accept_in),
    .software_break_instruction_in(software_break_instruction_in),
    .irq_out(irq_out), .vector_out(vector_out), .request_out(request_out),
    .enable_out(enable_out), .idis_out(idis_out));
`default_nettype wire

//--- sim/tb_vectored_interrupt_control.sv
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb_vectored_interrupt_control
    import vic_pkg::*;
;
    logic sys_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [8:0] pin = 9'h000;
    logic [13:0] evt = 14'h0000;
    wire ext_irq_zero_pin_a_in, ext_irq_zero_pin_b_in, ext_irq_one_in;
    wire ext_irq_two_in, ext_irq_three_in, ext_irq_four_pin_a_in;
    wire ext_irq_four_pin_b_in, counter0_pin_in, counter1_pin_in;
    wire timer_z_evt_in, serial1_rx_evt_in, serial1_tx_evt_in;
    wire timer_x_evt_in, timer_y_evt_in, timer_1_evt_in, timer_2_evt_in;
    wire serial3_rx_evt_in, serial2_evt_in, counter2_evt_in, adc_evt_in;
    wire serial3_tx_evt_in, twi_evt_in, twi_line_evt_in;
    logic [8:0] edge_polarity_in = 9'h1ff;
    logic [7:0] source_select_in = 8'h00;
    logic [14:0] enable_wr_data_in = 15'h0000;
    logic [14:0] request_wr_data_in = 15'h7fff;
    logic ext_pin_switch_in = 1'b0, enable_wr_in = 1'b0;
    logic request_wr_in = 1'b0, set_idis_in = 1'b0, clear_idis_in = 1'b0;
    logic software_break_instruction_in = 1'b0, hold = 1'b1;
    logic accept_in, irq_out, idis_out;
    logic [3:0] vector_out, last_vec, delay = 4'h0;
    logic [14:0] request_out, enable_out;
    int n_errors = 0, tests_run = 0;
    int ev_mask [14] = '{16'h0001, 16'h0004, 16'h0008, 16'h0010, 16'h0020,
        16'h0040, 16'h0080, 16'h0200, 16'h0400, 16'h2000, 16'h4000, 16'h4000,
        16'h0000, 16'h0000};
    int pin_line [9] = '{0, 0, 1, 11, 12, 13, 13, 8, 9};
    int pr_vec [3] = '{5, 6, 8};
    int pr_req [3] = '{'ha0, 'h80, 'h00};
    assign {counter1_pin_in, counter0_pin_in, ext_irq_four_pin_b_in,
        ext_irq_four_pin_a_in, ext_irq_three_in, ext_irq_two_in,
        ext_irq_one_in, ext_irq_zero_pin_b_in, ext_irq_zero_pin_a_in} = pin;
    assign {twi_line_evt_in, twi_evt_in, serial3_tx_evt_in, adc_evt_in,
        counter2_evt_in, serial2_evt_in, serial3_rx_evt_in, timer_2_evt_in,
        timer_1_evt_in, timer_y_evt_in, timer_x_evt_in, serial1_tx_evt_in,
        serial1_rx_evt_in, timer_z_evt_in} = evt;
    always #10 sys_clk_in = ~sys_clk_in;
    vic_top #(.TWI_VARIANT(1'b0)) dut_u (.*);
    vic_core_model core_u (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
        .irq_in(irq_out), .vector_in(vector_out), .hold_in(hold),
        .delay_in(delay), .accept_out(accept_in), .last_vec_out(last_vec));
    // ====================
    // Access tasks
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask : cyc
    task automatic strobe(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
        cyc(1);
    endtask : strobe
    task automatic wr_req(input logic [14:0] d);
        request_wr_data_in = d;
        strobe(request_wr_in);
    endtask : wr_req
    task automatic wr_en(input logic [14:0] d);
        enable_wr_data_in = d;
        strobe(enable_wr_in);
    endtask : wr_en
    task automatic take();
        hold <= 1'b0;
        for (int i = 0; i < 20 && irq_out !== 1'b0; i++)
            cyc(1);
        hold <= 1'b1;
        if (irq_out !== 1'b0)
        begin
            n_errors++;
            results();
        end
        cyc(2);
    endtask : take
    // ====================
    // Test sequence
    initial
    begin
        cyc(16);
        reset_in = 1'b0;
        cyc(1);
        check("irq", 16'(irq_out), 16'h0001);
        check("vector", 16'(vector_out), 16'(VIC_VEC_RESET));
        check("request", 16'(request_out), 16'h0000);
        check("enable", 16'(enable_out), 16'h0000);
        check("idis", 16'(idis_out), 16'h0001);
        take();
        $display("test reset done");
        for (int i = 0; i < 14; i++)
        begin
            source_select_in = (i == 0) ? 8'h01 : (i == 7) ? 8'h08 :
                (i == 9) ? 8'h40 : (i == 11) ? 8'h80 : (i == 12) ? 8'h20 :
                (i == 13) ? 8'h06 : 8'h00;
            cyc(4);
            wr_req(15'h0000);
            evt = 14'(1 << i);
            cyc(1);
            evt = 14'h0000;
            cyc(3);
            check("req", 16'(request_out), 16'(ev_mask[i]));
            check("irq", 16'(irq_out), 16'h0000);
        end
        source_select_in = 8'h00;
        $display("test sources done");
        for (int i = 0; i < 9; i++)
        begin
            ext_pin_switch_in = (i == 1 || i == 6);
            edge_polarity_in = (i % 2 == 0) ? 9'h1ff : 9'h000;
            pin[i] = ~edge_polarity_in[i];
            cyc(8);
            wr_req(15'h0000);
            pin[i] = edge_polarity_in[i];
            cyc(8);
            check("req", 16'(request_out), 16'(1 << pin_line[i]));
            pin[i] = 1'b0;
            cyc(8);
        end
        $display("test pins done");
        wr_req(15'h0000);
        wr_en(15'h7fff);
        check("enable", 16'(enable_out), 16'h7fff);
        wr_en(15'h00b0);
        evt = 14'h0058;
        cyc(1);
        evt = 14'h0000;
        cyc(3);
        check("irq", 16'(irq_out), 16'h0000);
        delay = 4'h3;
        for (int i = 0; i < 3; i++)
        begin
            strobe(clear_idis_in);
            check("vector", 16'(vector_out), 16'(pr_vec[i]));
            take();
            check("taken", 16'(last_vec), 16'(pr_vec[i]));
            check("request", 16'(request_out), 16'(pr_req[i]));
            check("idis", 16'(idis_out), 16'h0001);
        end
        $display("test priority done");
        evt = 14'h0040;
        cyc(1);
        evt = 14'h0000;
        strobe(clear_idis_in);
        check("irq", 16'(irq_out), 16'h0001);
        strobe(set_idis_in);
        check("irq", 16'(irq_out), 16'h0000);
        wr_en(15'h0000);
        check("enable", 16'(enable_out), 16'h0000);
        wr_req(15'h7fff);
        check("request", 16'(request_out), 16'h0080);
        wr_req(15'h7f7f);
        check("request", 16'(request_out), 16'h0000);
        $display("test masking done");
        strobe(software_break_instruction_in);
        cyc(1);
        check("irq", 16'(irq_out), 16'h0001);
        check("vector", 16'(vector_out), 16'(VIC_VEC_BREAK));
        take();
        $display("test break done");
        evt = 14'h0400;
        cyc(1);
        evt = 14'h0000;
        wr_en(15'h4000);
        strobe(clear_idis_in);
        take();
        check("taken", 16'(last_vec), 16'h000f);
        check("request", 16'(request_out), 16'h0000);
        $display("test last line done");
        results();
    end
endmodule : tb_vectored_interrupt_control
`default_nettype wire
